// ===== design/fcd_core.v
// fcd_core.v: four channel dma sequencer with host register port, input synchroniser and byte fifo
// assumes one clock, pins sampled through three flops, tri-state wires resolved outside from the enables
// Operation
// - eight one-hot states; transfer starts after grant
// - not ready inserts wait before fourth state
// - memory move: four read, four write states
// - idle samples requests, raises hold request
// - program condition needs select low, grant low
// - low address selects register, strobes give direction
// - byte pointer picks low/high byte, clearable
// - software commands decoded from address only
// - single mode: one byte per hold handshake
// - count rollover raises terminal count, autoinit
// - block mode runs until count end
// - demand mode follows request; autoinit needs edge
// - cascade channel only acknowledges, no bus drive
// - transfer types pair strobes; verify drives none
// - memory move: channel 0 source, 1 destination
// - move: fixed source, no acknowledge, stops on end
// - autoinit reloads from base, mask untouched
// - fixed or rotating priority
// - arbitrate at grant edge, never preempt
// - compressed timing drops third state
// - upper address state on byte carry and on every byte of a memory move
// - end of process sets status, clears request
// - pulse end line low on count rollover
// - software request accepted in block mode only
`timescale 1ns/1ps
`include "fcd_defs.vh"

module fcd_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire [W-1:0] async,
	output reg [W-1:0] filt
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;
	integer k;
	// a bit only moves once the two later stages agree
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			filt <= INIT;
		end else begin
			s1 <= async;
			s2 <= s1;
			s3 <= s2;
			for (k = 0; k < W; k = k + 1) begin
				if (s2[k] == s3[k])
					filt[k] <= s3[k];
			end
		end
	end
endmodule

module fcd_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire flush,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_q;
	reg [AW-1:0] rdPtr_q;
	reg [AW:0] count_q;
	wire push = inValid && inReady;
	wire pop = outValid && outReady;
	assign inReady = count_q != DEPTH[AW:0];
	assign outValid = count_q != {(AW+1){1'b0}};
	assign outData = mem[rdPtr_q];
	always @(posedge sys_clk) begin
		if (sys_rst || flush) begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem[wrPtr_q] <= inData;
				wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
			end
			if (pop)
				rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule

module fcd_core (
	input wire sys_clk,
	input wire sys_rst,
	input wire chipSelectN,
	input wire ioReadInN,
	input wire ioWriteInN,
	input wire [3:0] addrIn,
	input wire [7:0] dataIn,
	input wire [3:0] channelRequestIn,
	input wire holdGrant,
	input wire readyIn,
	input wire endOfProcessInN,
	output reg holdRequest,
	output reg [3:0] channelAcknowledgeOut,
	output reg addressEnable,
	output reg upperAddressStrobe,
	output reg [7:0] addrOut,
	output reg addrOe,
	output reg [7:0] dataOut,
	output reg dataOe,
	output reg ioReadOutN,
	output reg ioWriteOutN,
	output reg ioStrobeOe,
	output reg memoryReadStrobeN,
	output reg memoryWriteStrobeN,
	output reg memStrobeOe,
	output reg endOfProcessOut,
	output reg endOfProcessOe,
	output reg terminalCount
);
	localparam ST_IDLE = 8'h01;
	localparam ST_HWAIT = 8'h02;
	localparam ST_S1 = 8'h04;
	localparam ST_S2 = 8'h08;
	localparam ST_S3 = 8'h10;
	localparam ST_SW = 8'h20;
	localparam ST_S4 = 8'h40;
	localparam ST_CASC = 8'h80;

	wire [21:0] sy;
	fcd_sync #(.W(22), .INIT(`FCD_SYNC_INIT)) uSync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.async({dataIn, endOfProcessInN, readyIn, holdGrant, channelRequestIn, addrIn, ioWriteInN, ioReadInN,
			chipSelectN}),
		.filt(sy)
	);
	wire csS = sy[0];
	wire iorS = sy[1];
	wire iowS = sy[2];
	wire [3:0] aS = sy[6:3];
	wire [3:0] reqS = sy[10:7];
	wire grantS = sy[11];
	wire readyS = sy[12];
	wire eopS = sy[13];
	wire [7:0] dS = sy[21:14];

	reg [7:0] state_q;
	reg [7:0] state_d;
	reg [1:0] chan_q;
	reg [1:0] chan_d;
	reg memPhase_q;
	reg memPhase_d;
	reg m2m_q;
	reg m2m_d;
	reg [7:0] cmd_q;
	reg [3:0] mask_q;
	reg [3:0] swReq_q;
	reg [3:0] tcStat_q;
	reg [3:0] needEdge_q;
	reg [7:0] temp_q;
	reg ff_q;
	reg [1:0] last_q;
	reg iorPrev_q;
	reg iowPrev_q;
	reg grantPrev_q;
	reg [5:0] mode_q [0:3];
	reg [15:0] baseA_q [0:3];
	reg [15:0] baseC_q [0:3];
	reg [15:0] curA_q [0:3];
	reg [15:0] curC_q [0:3];
	integer i;
	integer j;

	function [2:0] fcdPick;
		input [3:0] r;
		input [1:0] s;
		reg [1:0] n;
		integer m;
		begin
			fcdPick = 3'h0;
			for (m = 3; m >= 0; m = m - 1) begin
				n = s + m[1:0];
				if (r[n])
					fcdPick = {1'b1, n};
			end
		end
	endfunction

	// host side decode
	wire progCond = (state_q == ST_IDLE) && !csS && !grantS;
	wire wrEv = progCond && iowS && !iowPrev_q;
	wire rdEndEv = progCond && iorS && !iorPrev_q;
	wire mclr = wrEv && (aS == `FCD_OFS_TEMP);
	wire [1:0] hc = aS[2:1];

	// requests and arbitration
	wire [3:0] dreqAct = cmd_q[`FCD_CMD_DREQLOW] ? ~reqS : reqS;
	wire [3:0] pend = ((dreqAct & ~mask_q & ~needEdge_q) | swReq_q) & {4{!cmd_q[`FCD_CMD_DISABLE]}};
	wire [1:0] rotStart = last_q + 2'h1;
	wire [2:0] pk = fcdPick(pend, cmd_q[`FCD_CMD_ROTATE] ? rotStart : 2'h0);

	// transfer bookkeeping at the fourth state
	wire [1:0] aCh = (m2m_q && memPhase_q) ? 2'h1 : chan_q;
	wire [5:0] md = mode_q[chan_q];
	wire [15:0] stepA = mode_q[aCh][`FCD_MD_DEC] ? curA_q[aCh] - 16'h0001 : curA_q[aCh] + 16'h0001;
	wire upperChg = stepA[15:8] != curA_q[aCh][15:8];
	wire holdSrc = m2m_q && !memPhase_q && cmd_q[`FCD_CMD_HOLD0];
	wire tcHit = (!m2m_q || memPhase_q) && (curC_q[aCh] == `FCD_COUNT_TC);
	wire endSvc = tcHit || !eopS;
	wire doneSvc = (state_q == ST_S4) && endSvc;
	wire [3:0] hitMask = m2m_q ? 4'h3 : (4'h1 << chan_q);
	reg cont;
	always @* begin
		case (md[`FCD_MD_MODE])
			`FCD_MODE_SINGLE: cont = 1'b0;
			`FCD_MODE_DEMAND: cont = dreqAct[chan_q];
			default: cont = 1'b1;
		endcase
	end

	wire fifoInReady;
	wire fifoOutValid;
	wire [7:0] fifoOut;
	wire fifoPush = (state_q == ST_S4) && m2m_q && !memPhase_q;
	wire fifoPop = (state_q == ST_S4) && m2m_q && memPhase_q;
	// the move byte passes this buffer; a full buffer stalls the read half, an empty one the write half
	fcd_fifo #(.WIDTH(8), .DEPTH(8), .AW(3)) uFifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.flush(mclr || doneSvc),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.inData(dS),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOut)
	);

	always @* begin
		state_d = state_q;
		chan_d = chan_q;
		memPhase_d = memPhase_q;
		m2m_d = m2m_q;
		case (state_q)
			ST_IDLE: if (pend != 4'h0 && !grantS && !progCond) state_d = ST_HWAIT;
			ST_HWAIT: if (grantS && !grantPrev_q) begin
				if (!pk[2]) begin
					state_d = ST_IDLE;
				end else begin
					chan_d = pk[1:0];
					memPhase_d = 1'b0;
					m2m_d = cmd_q[`FCD_CMD_M2M] && pk[1:0] == 2'h0 && swReq_q[0];
					state_d = (mode_q[pk[1:0]][`FCD_MD_MODE] == `FCD_MODE_CASCADE) ? ST_CASC : ST_S1;
				end
			end
			ST_CASC: if (!dreqAct[chan_q]) state_d = ST_IDLE;
			ST_S1: state_d = ST_S2;
			ST_S2: if (!m2m_q || (memPhase_q ? fifoOutValid : fifoInReady)) begin
				if (cmd_q[`FCD_CMD_COMPR] && !m2m_q)
					state_d = readyS ? ST_S4 : ST_SW;
				else
					state_d = ST_S3;
			end
			ST_S3: state_d = readyS ? ST_S4 : ST_SW;
			ST_SW: if (readyS) state_d = ST_S4;
			ST_S4: begin
				if (m2m_q)
					memPhase_d = !memPhase_q;
				if (endSvc || (!m2m_q && !cont)) begin
					state_d = ST_IDLE;
					m2m_d = 1'b0;
				end else begin
					state_d = (upperChg || m2m_q) ? ST_S1 : ST_S2;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// control state; master clear acts as reset except on the channel registers
	always @(posedge sys_clk) begin
		if (sys_rst || mclr) begin
			state_q <= ST_IDLE;
			chan_q <= 2'h0;
			memPhase_q <= 1'b0;
			m2m_q <= 1'b0;
			cmd_q <= `FCD_CMD_RST;
			mask_q <= `FCD_MASK_RST;
			swReq_q <= 4'h0;
			tcStat_q <= 4'h0;
			needEdge_q <= 4'h0;
			temp_q <= 8'h00;
			ff_q <= 1'b0;
			last_q <= 2'h3;
		end else begin
			state_q <= state_d;
			chan_q <= chan_d;
			memPhase_q <= memPhase_d;
			m2m_q <= m2m_d;
			if (wrEv) begin
				case (aS)
					`FCD_OFS_STATUS: cmd_q <= dS;
					`FCD_OFS_REQ: begin
						if (!dS[2])
							swReq_q[dS[1:0]] <= 1'b0;
						else if (mode_q[dS[1:0]][`FCD_MD_MODE] == `FCD_MODE_BLOCK &&
							(!cmd_q[`FCD_CMD_M2M] || dS[1:0] == 2'h0))
							swReq_q[dS[1:0]] <= 1'b1;
					end
					`FCD_OFS_MASK1: mask_q[dS[1:0]] <= dS[2];
					`FCD_OFS_CLRFF: ff_q <= 1'b0;
					`FCD_OFS_CLRMASK: mask_q <= 4'h0;
					`FCD_OFS_MASKALL: mask_q <= dS[3:0];
					default: ;
				endcase
			end
			if ((wrEv || rdEndEv) && !aS[3])
				ff_q <= !ff_q;
			if (rdEndEv && aS == `FCD_OFS_STATUS)
				tcStat_q <= 4'h0;
			if (state_q == ST_HWAIT && pk[2] && grantS && !grantPrev_q)
				last_q <= pk[1:0];
			for (j = 0; j < 4; j = j + 1) begin
				if (!dreqAct[j])
					needEdge_q[j] <= 1'b0;
			end
			if (fifoPop)
				temp_q <= fifoOut;
			if (doneSvc) begin
				tcStat_q <= tcStat_q | hitMask;
				swReq_q <= swReq_q & ~hitMask;
				for (j = 0; j < 4; j = j + 1) begin
					if (hitMask[j] && mode_q[j][`FCD_MD_AUTO]) begin
						if (mode_q[j][`FCD_MD_MODE] == `FCD_MODE_DEMAND)
							needEdge_q[j] <= 1'b1;
					end else if (hitMask[j]) begin
						mask_q[j] <= 1'b1;
					end
				end
			end
		end
	end

	// channel registers; base and current are written together by the host
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			for (i = 0; i < 4; i = i + 1) begin
				mode_q[i] <= `FCD_MODE_RST;
				baseA_q[i] <= 16'h0000;
				baseC_q[i] <= 16'h0000;
				curA_q[i] <= 16'h0000;
				curC_q[i] <= 16'h0000;
			end
		end else begin
			if (wrEv && !aS[3]) begin
				if (aS[0] && ff_q) begin
					baseC_q[hc][15:8] <= dS;
					curC_q[hc][15:8] <= dS;
				end else if (aS[0]) begin
					baseC_q[hc][7:0] <= dS;
					curC_q[hc][7:0] <= dS;
				end else if (ff_q) begin
					baseA_q[hc][15:8] <= dS;
					curA_q[hc][15:8] <= dS;
				end else begin
					baseA_q[hc][7:0] <= dS;
					curA_q[hc][7:0] <= dS;
				end
			end
			if (wrEv && aS == `FCD_OFS_MODE)
				mode_q[dS[1:0]] <= dS[7:2];
			if (state_q == ST_S4) begin
				if (!holdSrc)
					curA_q[aCh] <= stepA;
				if (!m2m_q || memPhase_q) begin
					curC_q[aCh] <= curC_q[aCh] - 16'h0001;
					if (m2m_q)
						curC_q[0] <= curC_q[0] - 16'h0001;
				end
				for (i = 0; i < 4; i = i + 1) begin
					if (endSvc && hitMask[i] && mode_q[i][`FCD_MD_AUTO]) begin
						curA_q[i] <= baseA_q[i];
						curC_q[i] <= baseC_q[i];
					end
				end
			end
		end
	end

	// read data for the host
	reg [7:0] rdData;
	always @* begin
		rdData = 8'h00;
		if (!aS[3])
			rdData = ff_q ? (aS[0] ? curC_q[hc][15:8] : curA_q[hc][15:8]) :
				(aS[0] ? curC_q[hc][7:0] : curA_q[hc][7:0]);
		else if (aS == `FCD_OFS_STATUS)
			rdData = {dreqAct | swReq_q, tcStat_q};
		else if (aS == `FCD_OFS_TEMP)
			rdData = temp_q;
	end

	// pin outputs, registered from the next state except end of process and terminal count, which follow the current state
	wire svcD = (state_d & 8'h7c) != 8'h00;
	wire rdPhase = (state_d & 8'h70) != 8'h00;
	wire wrPhase = (state_d & 8'h60) != 8'h00;
	wire [1:0] aChD = (m2m_d && memPhase_d) ? 2'h1 : chan_d;
	wire [1:0] typD = mode_q[chan_d][`FCD_MD_TYPE];
	// forward the stepped address so the next transfer never shows the stale one
	wire [15:0] addrNow = (state_q == ST_S4 && aCh == aChD && !holdSrc) ? stepA : curA_q[aChD];
	wire dackOn = (svcD && !m2m_d) || state_d == ST_CASC;
	wire [3:0] dackHot = dackOn ? (4'h1 << chan_d) : 4'h0;
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			iorPrev_q <= 1'b1;
			iowPrev_q <= 1'b1;
			grantPrev_q <= 1'b0;
			holdRequest <= 1'b0;
			channelAcknowledgeOut <= 4'hf;
			addressEnable <= 1'b0;
			upperAddressStrobe <= 1'b0;
			addrOut <= 8'h00;
			addrOe <= 1'b0;
			dataOut <= 8'h00;
			dataOe <= 1'b0;
			ioReadOutN <= 1'b1;
			ioWriteOutN <= 1'b1;
			ioStrobeOe <= 1'b0;
			memoryReadStrobeN <= 1'b1;
			memoryWriteStrobeN <= 1'b1;
			memStrobeOe <= 1'b0;
			endOfProcessOut <= 1'b0;
			endOfProcessOe <= 1'b0;
			terminalCount <= 1'b0;
		end else begin
			iorPrev_q <= iorS;
			iowPrev_q <= iowS;
			grantPrev_q <= grantS;
			holdRequest <= state_d != ST_IDLE;
			channelAcknowledgeOut <= cmd_q[`FCD_CMD_DACKHIGH] ? dackHot : ~dackHot;
			addressEnable <= svcD;
			upperAddressStrobe <= state_d == ST_S1;
			addrOut <= addrNow[7:0];
			addrOe <= svcD;
			if (state_d == ST_S1) begin
				dataOut <= addrNow[15:8];
				dataOe <= 1'b1;
			end else if (svcD && m2m_d && memPhase_d) begin
				dataOut <= fifoOut;
				dataOe <= 1'b1;
			end else begin
				dataOut <= rdData;
				dataOe <= progCond && !iorS;
			end
			// verify type matches neither pairing, so no strobe moves
			ioReadOutN <= !(!m2m_d && typD == `FCD_TYPE_WRITE && rdPhase);
			memoryWriteStrobeN <= !(m2m_d ? (memPhase_d && wrPhase) : (typD == `FCD_TYPE_WRITE && wrPhase));
			memoryReadStrobeN <= !(m2m_d ? (!memPhase_d && rdPhase) : (typD == `FCD_TYPE_READ && rdPhase));
			ioWriteOutN <= !(!m2m_d && typD == `FCD_TYPE_READ && wrPhase);
			ioStrobeOe <= svcD;
			memStrobeOe <= svcD;
			endOfProcessOut <= 1'b0;
			endOfProcessOe <= (state_q == ST_S4) && tcHit;
			terminalCount <= (state_q == ST_S4) && tcHit;
		end
	end
endmodule

// ===== design/fcd_defs.vh
// fcd_defs.vh: register offsets, field positions and reset values of the four channel dma core
// assumes inclusion by bare name from the core file
`ifndef FCD_DEFS_VH
`define FCD_DEFS_VH
// host port offsets above the channel registers (0..7: address and count of channels 0..3)
`define FCD_OFS_STATUS 4'h8
`define FCD_OFS_REQ 4'h9
`define FCD_OFS_MASK1 4'ha
`define FCD_OFS_MODE 4'hb
`define FCD_OFS_CLRFF 4'hc
`define FCD_OFS_TEMP 4'hd
`define FCD_OFS_CLRMASK 4'he
`define FCD_OFS_MASKALL 4'hf
// command register bits
`define FCD_CMD_M2M 0
`define FCD_CMD_HOLD0 1
`define FCD_CMD_DISABLE 2
`define FCD_CMD_COMPR 3
`define FCD_CMD_ROTATE 4
`define FCD_CMD_DREQLOW 6
`define FCD_CMD_DACKHIGH 7
// stored mode fields (written data bits 7..2)
`define FCD_MD_TYPE 1:0
`define FCD_MD_AUTO 2
`define FCD_MD_DEC 3
`define FCD_MD_MODE 5:4
`define FCD_TYPE_WRITE 2'h1
`define FCD_TYPE_READ 2'h2
`define FCD_MODE_DEMAND 2'h0
`define FCD_MODE_SINGLE 2'h1
`define FCD_MODE_BLOCK 2'h2
`define FCD_MODE_CASCADE 2'h3
// reset values
`define FCD_CMD_RST 8'h00
`define FCD_MASK_RST 4'hf
`define FCD_MODE_RST 6'h00
`define FCD_COUNT_TC 16'h0000
`define FCD_SYNC_INIT 22'h002007
`endif

// ===== verif/fcd_core_monitor.sv
// fcd_core_monitor.sv: port-level assertions for the four channel dma core
// assumes sys_clk and the synchronous active high sys_rst of the core
`timescale 1ns/1ps
module fcd_core_monitor (
	input wire sys_clk,
	input wire sys_rst,
	input wire holdGrant,
	input wire holdRequest,
	input wire [3:0] channelAcknowledgeOut,
	input wire addressEnable,
	input wire upperAddressStrobe,
	input wire dataOe,
	input wire ioReadOutN,
	input wire ioWriteOutN,
	input wire ioStrobeOe,
	input wire memoryReadStrobeN,
	input wire memStrobeOe,
	input wire endOfProcessOut,
	input wire endOfProcessOe,
	input wire terminalCount
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	// grant passes the input flops before any state can follow it
	property p_grantFirst;
		$rose(addressEnable) |-> $past(holdGrant, 2);
	endproperty
	a_grantFirst: assert property (p_grantFirst) else $error("bus taken before grant");
	// either ack polarity: two bits set means two channels active
	property p_ackOne;
		$countones(channelAcknowledgeOut) != 2;
	endproperty
	a_ackOne: assert property (p_ackOne) else $error("two acknowledges");
	property p_ackHold;
		$countones(channelAcknowledgeOut) inside {1, 3} |-> holdRequest || $past(holdRequest);
	endproperty
	a_ackHold: assert property (p_ackHold) else $error("acknowledge without bus");
	property p_stbPulse;
		upperAddressStrobe |=> !upperAddressStrobe;
	endproperty
	a_stbPulse: assert property (p_stbPulse) else $error("address strobe too long");
	property p_stbAen;
		upperAddressStrobe |-> addressEnable && dataOe;
	endproperty
	a_stbAen: assert property (p_stbAen) else $error("upper byte not driven");
	property p_eopPulse;
		endOfProcessOe |=> !endOfProcessOe;
	endproperty
	a_eopPulse: assert property (p_eopPulse) else $error("end pulse too long");
	property p_eopLow;
		endOfProcessOe |-> endOfProcessOut == 1'b0 && terminalCount;
	endproperty
	a_eopLow: assert property (p_eopLow) else $error("end pulse without count end");
	property p_ioExcl;
		ioStrobeOe |-> ioReadOutN || ioWriteOutN;
	endproperty
	a_ioExcl: assert property (p_ioExcl) else $error("both io strobes low");
	property p_pairWrite;
		ioStrobeOe && memStrobeOe && !ioReadOutN |-> memoryReadStrobeN;
	endproperty
	a_pairWrite: assert property (p_pairWrite) else $error("io read with memory read");
	property p_aenHold;
		addressEnable |-> holdRequest;
	endproperty
	a_aenHold: assert property (p_aenHold) else $error("address enable without bus request");
endmodule
bind fcd_core fcd_core_monitor fcd_core_monitor_inst (.sys_clk, .sys_rst, .holdGrant, .holdRequest,
	.channelAcknowledgeOut, .addressEnable, .upperAddressStrobe, .dataOe, .ioReadOutN, .ioWriteOutN,
	.ioStrobeOe, .memoryReadStrobeN, .memStrobeOe, .endOfProcessOut, .endOfProcessOe, .terminalCount);

// ===== verif/fcd_core_tb.sv
// fcd_core_tb.sv: self-checking bench for the four channel dma core
// assumes fcd_partner as host and peripherals, checker bound to the core
`timescale 1ns/1ps
module fcd_core_tb;
	reg sys_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg chipSelectN = 1'b1;
	reg ioReadInN = 1'b1;
	reg ioWriteInN = 1'b1;
	reg [3:0] addrIn = 4'h0;
	reg [7:0] dataIn = 8'h00;
	reg endOfProcessInN = 1'b1;
	reg [3:0] want = 4'h0;
	reg [3:0] slow = 4'h0;
	reg hPrev = 1'b0;
	wire [3:0] channelRequestIn;
	wire holdGrant;
	wire readyIn;
	wire holdRequest;
	wire [3:0] channelAcknowledgeOut;
	wire addressEnable;
	wire upperAddressStrobe;
	wire [7:0] dataOut;
	wire dataOe;
	wire ioReadOutN;
	wire ioWriteOutN;
	wire ioStrobeOe;
	wire memoryReadStrobeN;
	wire memoryWriteStrobeN;
	wire memStrobeOe;
	wire endOfProcessOe;
	wire terminalCount;
	integer fails = 0;
	integer checked = 0;
	integer nIoRd, nIoWr, nMemRd, nMemWr, nStb, nHold, nTc, nEop, nAck;
	always #4 sys_clk = ~sys_clk;
	fcd_core fcd_core_inst (.sys_clk, .sys_rst, .chipSelectN, .ioReadInN, .ioWriteInN, .addrIn, .dataIn,
		.channelRequestIn, .holdGrant, .readyIn, .endOfProcessInN, .holdRequest, .channelAcknowledgeOut,
		.addressEnable, .upperAddressStrobe, .addrOut(), .addrOe(), .dataOut, .dataOe, .ioReadOutN,
		.ioWriteOutN, .ioStrobeOe, .memoryReadStrobeN, .memoryWriteStrobeN, .memStrobeOe,
		.endOfProcessOut(), .endOfProcessOe, .terminalCount);
	fcd_partner fcd_partner_inst (.sys_clk, .sys_rst, .want, .slow, .holdRequest, .channelAcknowledgeOut,
		.ioStrobeOe, .memStrobeOe, .holdGrant, .channelRequestIn, .readyIn);
	// strobe cycles and event counts of the latest service
	always @(posedge sys_clk) begin
		hPrev <= holdRequest;
		nIoRd <= nIoRd + (ioStrobeOe & ~ioReadOutN);
		nIoWr <= nIoWr + (ioStrobeOe & ~ioWriteOutN);
		nMemRd <= nMemRd + (memStrobeOe & ~memoryReadStrobeN);
		nMemWr <= nMemWr + (memStrobeOe & ~memoryWriteStrobeN);
		nStb <= nStb + upperAddressStrobe;
		nHold <= nHold + (holdRequest & ~hPrev);
		nTc <= nTc + terminalCount;
		nEop <= nEop + endOfProcessOe;
		nAck <= nAck + (channelAcknowledgeOut != 4'hf);
	end
	task stop_test;
		begin
			$display("checked %0d fails %0d", checked, fails);
			if (fails == 0 && checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// strobes held well past the input flops so each edge is seen once
	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge sys_clk);
			chipSelectN <= 1'b0;
			addrIn <= a;
			dataIn <= d;
			ioWriteInN <= 1'b0;
			repeat (6) @(posedge sys_clk);
			ioWriteInN <= 1'b1;
			repeat (8) @(posedge sys_clk);
			chipSelectN <= 1'b1;
		end
	endtask
	task rd(input [3:0] a, input [7:0] exp);
		begin
			@(posedge sys_clk);
			chipSelectN <= 1'b0;
			addrIn <= a;
			ioReadInN <= 1'b0;
			repeat (8) @(posedge sys_clk);
			#1;
			chk(dataOe, 1'b1);
			chk(dataOut, exp);
			@(posedge sys_clk);
			ioReadInN <= 1'b1;
			repeat (8) @(posedge sys_clk);
			chipSelectN <= 1'b1;
		end
	endtask
	task waitHold(input v);
		integer i;
		begin
			i = 0;
			while (holdRequest !== v && i < 400) begin
				@(posedge sys_clk);
				i = i + 1;
			end
			if (holdRequest !== v) begin
				fails = fails + 1;
				stop_test;
			end
		end
	endtask
	task req(input [3:0] m);
		begin
			@(negedge sys_clk);
			{nIoRd, nIoWr, nMemRd, nMemWr, nStb, nHold, nTc, nEop, nAck} = 0;
			@(posedge sys_clk);
			want <= m;
			@(posedge sys_clk);
			want <= 4'h0;
		end
	endtask
	task serve(input [3:0] m);
		begin
			req(m);
			waitHold(1'b1);
			waitHold(1'b0);
			repeat (12) @(posedge sys_clk);
		end
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk(holdRequest, 1'b0);
		chk(channelAcknowledgeOut, 4'hf);
		// single write on channel 0, count 0000 so the first byte ends it
		wr(4'h8, 8'h00);
		wr(4'he, 8'h5a);
		wr(4'hb, 8'h44);
		wr(4'hc, 8'h00);
		wr(4'h0, 8'hff);
		wr(4'h0, 8'h00);
		wr(4'h1, 8'h00);
		wr(4'h1, 8'h00);
		serve(4'h1);
		chk(nHold, 1);
		chk(nStb, 1);
		chk(nIoRd != 0 && nMemWr != 0, 1);
		chk(nIoWr + nMemRd, 0);
		chk(nTc, 1);
		chk(nEop, 1);
		rd(4'h8, 8'h01);
		wr(4'hc, 8'h00);
		rd(4'h0, 8'h00);
		rd(4'h0, 8'h01);
		rd(4'h1, 8'hff);
		rd(4'h1, 8'hff);
		// block read on channel 1, decrementing, two bytes, slow memory
		wr(4'hb, 8'ha9);
		wr(4'hc, 8'h00);
		wr(4'h2, 8'h05);
		wr(4'h2, 8'h00);
		wr(4'h3, 8'h01);
		wr(4'h3, 8'h00);
		wr(4'ha, 8'h01);
		slow <= 4'h6;
		serve(4'h2);
		chk(nHold, 1);
		chk(nStb, 1);
		chk(nMemRd > 4, 1);
		chk(nIoWr != 0, 1);
		chk(nIoRd + nMemWr, 0);
		chk(nTc, 1);
		rd(4'h8, 8'h02);
		wr(4'hc, 8'h00);
		rd(4'h2, 8'h03);
		rd(4'h2, 8'h00);
		// channel masked after its count ended without autoinit
		req(4'h2);
		repeat (40) @(posedge sys_clk);
		chk(nHold, 0);
		// byte pointer cleared by command and by master clear
		wr(4'hc, 8'hff);
		wr(4'h4, 8'h34);
		wr(4'h4, 8'h12);
		wr(4'hc, 8'h00);
		rd(4'h4, 8'h34);
		rd(4'h4, 8'h12);
		wr(4'h4, 8'h56);
		wr(4'hd, 8'h00);
		rd(4'h4, 8'h56);
		// software request: refused in single mode, taken in block mode
		wr(4'hb, 8'h42);
		wr(4'hc, 8'h00);
		wr(4'h5, 8'h00);
		wr(4'h5, 8'h00);
		req(4'h0);
		wr(4'h9, 8'h06);
		repeat (40) @(posedge sys_clk);
		chk(nHold, 0);
		wr(4'hb, 8'h82);
		wr(4'h9, 8'h06);
		waitHold(1'b1);
		waitHold(1'b0);
		repeat (12) @(posedge sys_clk);
		chk(nHold, 1);
		chk(nIoRd + nIoWr + nMemRd + nMemWr, 0);
		chk(nTc, 1);
		wr(4'hc, 8'h00);
		rd(4'h4, 8'h57);
		// memory move of two bytes, channel 1 autoinit; channel 1 pin still high from the masked test
		wr(4'hd, 8'h00);
		wr(4'h8, 8'h01);
		wr(4'hb, 8'h80);
		wr(4'hb, 8'h91);
		wr(4'hc, 8'h00);
		wr(4'h0, 8'h10);
		wr(4'h0, 8'h00);
		wr(4'h1, 8'h01);
		wr(4'h1, 8'h00);
		wr(4'h2, 8'h20);
		wr(4'h2, 8'h00);
		wr(4'h3, 8'h01);
		wr(4'h3, 8'h00);
		req(4'h0);
		wr(4'h9, 8'h04);
		dataIn <= 8'h3c;
		waitHold(1'b1);
		waitHold(1'b0);
		repeat (12) @(posedge sys_clk);
		chk(nHold, 1);
		chk(nStb, 4);
		chk(nMemRd != 0 && nMemWr != 0, 1);
		chk(nIoRd + nIoWr, 0);
		chk(nAck, 0);
		chk(nTc, 1);
		chk(nEop, 1);
		rd(4'hd, 8'h3c);
		rd(4'h8, 8'h23);
		wr(4'hc, 8'h00);
		rd(4'h2, 8'h20);
		rd(4'h2, 8'h00);
		rd(4'h0, 8'h12);
		stop_test;
	end
endmodule

// ===== verif/fcd_partner.sv
// fcd_partner.sv: host grant and peripheral request model facing the dma core
// assumes reset polarities: requests high active, acknowledges low active
`timescale 1ns/1ps
module fcd_partner (
	input wire sys_clk,
	input wire sys_rst,
	input wire [3:0] want,
	input wire [3:0] slow,
	input wire holdRequest,
	input wire [3:0] channelAcknowledgeOut,
	input wire ioStrobeOe,
	input wire memStrobeOe,
	output reg holdGrant,
	output reg [3:0] channelRequestIn,
	output wire readyIn
);
	reg [3:0] rdyCntQ;
	// slow memory: not ready for the first slow cycles of a service
	assign readyIn = rdyCntQ >= slow;
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			holdGrant <= 1'b0;
			channelRequestIn <= 4'h0;
			rdyCntQ <= 4'h0;
		end else begin
			holdGrant <= holdRequest;
			// a request stays up until its acknowledge shows
			channelRequestIn <= want | (channelRequestIn & channelAcknowledgeOut);
			if (!(ioStrobeOe || memStrobeOe))
				rdyCntQ <= 4'h0;
			else if (rdyCntQ != 4'hf)
				rdyCntQ <= rdyCntQ + 4'h1;
		end
	end
endmodule
